//--- hdl/ust_usart_sync.sv
// synchronous usart: receive path, fifo, slave and master transmit
// Function
// - receive starts when single or continuous enabled
// - data sampled on shift clock falling edge
// - single enable receives one word then stops
// - continuous enable keeps receiving until cleared
// - both enables set behaves as continuous
// - finished word moves to fifo if room
// - completed transfer sets rx flag; enable gates irq
// - rx flag read-only, clears when fifo empty
// - two-deep fifo, in-order reads
// - full fifo at word end sets overrun, drops
// - overrun stays until continuous enable cleared
// - overrun blocks all transfers into fifo
// - ninth bit queued with its data word
// - buffer read exposes next word's status bits
// - clearing enables or port resets receiver
// - slave mode uses external clock, runs asleep
// - second buffered word holds tx flag clear
// - tx flag with enable wakes device
// - clearing port or transmit enable resets transmitter
// - half duplex, rx and tx exclusive
// - master drives shift clock pin
// - baud generator reset when all enables clear
`timescale 1ns/1ps
module ust_usart_sync #(
  parameter int DEPTH = ust_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // shift clock pin
  input wire logic i_ck,
  output logic o_ck,
  output logic o_ck_oe,
  // serial data pin
  input wire logic i_dt,
  output logic o_dt,
  output logic o_dt_oe,
  // interrupt and wake request
  output logic o_irq
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  // pin synchronisers
  logic ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
  // control registers
  logic serial_port_enable_q, rx9_q, single_word_rx_enable_q, continuous_rx_enable_q;
  logic clock_source_select_q, tx9_q, transmit_enable_q, sync_q, tx_ninth_bit_q;
  logic [1:0] irq_en_q;
  logic [7:0] baud_q, rdata_q;
  // baud generator
  logic [7:0] brg_cnt_q;
  logic ck_q;
  // receive state
  logic [8:0] rsr_q;
  logic [3:0] rx_cnt_q;
  logic overrun_error_flag_q;
  ust_pkg::ust_rx_word_t mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  // transmit state
  logic [7:0] txbuf_q;
  logic txbuf_full_q, tsr_busy_q, dt_q;
  logic [8:0] tsr_q;
  logic [3:0] tx_cnt_q;
  ust_pkg::ust_mode_t mode_q, mode_d;

  logic active, rx_en, tx_on, brg_run, tick, rise_ev, fall_ev;
  logic wr_rxcs, wr_txcs, wr_txbuf, rd_rxbuf;
  logic [3:0] rx_bits, tx_bits;
  logic [8:0] rx_new;
  logic rx_last, full, push, pop, tx_load, rx_flag, tx_flag;
  ust_pkg::ust_rx_word_t rx_word, head;

  assign active = serial_port_enable_q & sync_q;
  assign rx_en = active & (single_word_rx_enable_q | continuous_rx_enable_q);
  assign tx_on = active & transmit_enable_q;
  assign wr_rxcs = i_wr & (i_addr == ust_pkg::ADDR_RX_CS);
  assign wr_txcs = i_wr & (i_addr == ust_pkg::ADDR_TX_CS);
  assign wr_txbuf = i_wr & (i_addr == ust_pkg::ADDR_TX_BUF);
  assign rd_rxbuf = i_rd & (i_addr == ust_pkg::ADDR_RX_BUF);
  assign rx_bits = rx9_q ? ust_pkg::BITS_9 : ust_pkg::BITS_8;
  assign tx_bits = tx9_q ? ust_pkg::BITS_9 : ust_pkg::BITS_8;

  // pin synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end else begin
      ck_s1_q <= i_ck;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= i_dt;
      dt_s2_q <= dt_s1_q;
    end
  end

  // line direction
  always_comb begin
    mode_d = ust_pkg::UST_IDLE;
    if (rx_en) begin
      mode_d = ust_pkg::UST_RX;
    end else if (tx_on) begin
      mode_d = ust_pkg::UST_TX;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_q <= ust_pkg::UST_IDLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // baud generator, master clock
  assign brg_run = active & clock_source_select_q & (rx_en | (tx_on & tsr_busy_q));
  assign tick = brg_run & (brg_cnt_q == baud_q);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !brg_run) begin
      brg_cnt_q <= 8'h00;
      ck_q <= 1'b0;
    end else if (tick) begin
      brg_cnt_q <= 8'h00;
      ck_q <= ~ck_q;
    end else begin
      brg_cnt_q <= brg_cnt_q + 8'h01;
    end
  end

  // shift clock edges, internal or external
  always_comb begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (clock_source_select_q) begin
      rise_ev = tick & ~ck_q;
      fall_ev = tick & ck_q;
    end else if (active) begin
      rise_ev = ck_s2_q & ~ck_s3_q;
      fall_ev = ~ck_s2_q & ck_s3_q;
    end
  end

  // control registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      serial_port_enable_q <= 1'b0;
      rx9_q <= 1'b0;
      continuous_rx_enable_q <= 1'b0;
    end else if (wr_rxcs) begin
      serial_port_enable_q <= i_wdata[ust_pkg::RX_SERIAL_PORT_ENABLE];
      rx9_q <= i_wdata[ust_pkg::RX_RX9];
      continuous_rx_enable_q <= i_wdata[ust_pkg::RX_CONTINUOUS_RX_ENABLE];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      single_word_rx_enable_q <= 1'b0;
    end else if (wr_rxcs) begin
      single_word_rx_enable_q <= i_wdata[ust_pkg::RX_SINGLE_WORD_RX_ENABLE];
    end else if (rx_last && !continuous_rx_enable_q) begin
      single_word_rx_enable_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      clock_source_select_q <= 1'b0;
      tx9_q <= 1'b0;
      transmit_enable_q <= 1'b0;
      sync_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
    end else if (wr_txcs) begin
      clock_source_select_q <= i_wdata[ust_pkg::TX_CLOCK_SOURCE_SELECT];
      tx9_q <= i_wdata[ust_pkg::TX_TX9];
      transmit_enable_q <= i_wdata[ust_pkg::TX_TRANSMIT_ENABLE];
      sync_q <= i_wdata[ust_pkg::TX_SYNC];
      tx_ninth_bit_q <= i_wdata[ust_pkg::TX_T9D];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_en_q <= ust_pkg::RST_IRQ_EN;
      baud_q <= ust_pkg::RST_BAUD;
    end else if (i_wr) begin
      if (i_addr == ust_pkg::ADDR_IRQ_EN) begin
        irq_en_q <= i_wdata[1:0];
      end
      if (i_addr == ust_pkg::ADDR_BAUD) begin
        baud_q <= i_wdata;
      end
    end
  end

  // receive shift register
  assign rx_last = fall_ev & (mode_q == ust_pkg::UST_RX) &
                   (rx_cnt_q == rx_bits - 4'h1);
  assign rx_new = {dt_s2_q, rsr_q[8:1]};
  assign full = (count_q == FULL_CNT);

  always_comb begin
    rx_word.framing_error_flag = 1'b0;
    rx_word.ninth = rx9_q & rx_new[8];
    rx_word.data = rx9_q ? rx_new[7:0] : rx_new[8:1];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !rx_en) begin
      rx_cnt_q <= 4'h0;
      rsr_q <= 9'h000;
    end else if (fall_ev && mode_q == ust_pkg::UST_RX) begin
      rsr_q <= rx_new;
      rx_cnt_q <= rx_last ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // overrun: set wins over the clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      overrun_error_flag_q <= 1'b0;
    end else if (rx_last && full) begin
      overrun_error_flag_q <= 1'b1;
    end else if (wr_rxcs && !i_wdata[ust_pkg::RX_CONTINUOUS_RX_ENABLE]) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // receive fifo
  assign push = rx_last & ~full & ~overrun_error_flag_q;
  assign pop = rd_rxbuf & (count_q != '0);
  assign head = mem_q[rd_ptr_q];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
        mem_q[i] <= '0;
      end else if (push && wr_ptr_q == PTR_W'(i)) begin
        mem_q[i] <= rx_word;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + PTR_W'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + CNT_W'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CNT_W'(1);
      end
    end
  end

  assign rx_flag = (count_q != '0);

  // transmit buffer and shift register
  assign tx_load = ~tsr_busy_q & txbuf_full_q & tx_on;
  assign tx_flag = ~txbuf_full_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      txbuf_q <= 8'h00;
      txbuf_full_q <= 1'b0;
    end else if (wr_txbuf) begin
      txbuf_q <= i_wdata;
      txbuf_full_q <= 1'b1;
    end else if (tx_load) begin
      txbuf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !tx_on) begin
      tsr_q <= 9'h000;
      tsr_busy_q <= 1'b0;
      tx_cnt_q <= 4'h0;
      dt_q <= 1'b0;
    end else if (tx_load) begin
      tsr_q <= {tx_ninth_bit_q, txbuf_q};
      tsr_busy_q <= 1'b1;
      tx_cnt_q <= 4'h0;
    end else if (rise_ev && tsr_busy_q && mode_q == ust_pkg::UST_TX) begin
      if (tx_cnt_q == tx_bits) begin
        tsr_busy_q <= 1'b0;
      end else begin
        dt_q <= tsr_q[0];
        tsr_q <= {1'b0, tsr_q[8:1]};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end

  // register read, one cycle later
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_q <= ust_pkg::RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        ust_pkg::ADDR_IRQ_FLAGS: rdata_q <= {6'h00, tx_flag, rx_flag};
        ust_pkg::ADDR_IRQ_EN: rdata_q <= {6'h00, irq_en_q};
        ust_pkg::ADDR_RX_CS: rdata_q <= {serial_port_enable_q, rx9_q, single_word_rx_enable_q, continuous_rx_enable_q,
                                         1'b0, head.framing_error_flag & rx_flag, overrun_error_flag_q,
                                         head.ninth & rx_flag};
        ust_pkg::ADDR_RX_BUF: rdata_q <= head.data;
        ust_pkg::ADDR_TX_CS: rdata_q <= {clock_source_select_q, tx9_q, transmit_enable_q, sync_q,
                                         2'b00, ~tsr_busy_q, tx_ninth_bit_q};
        ust_pkg::ADDR_TX_BUF: rdata_q <= txbuf_q;
        ust_pkg::ADDR_BAUD: rdata_q <= baud_q;
        default: rdata_q <= ust_pkg::RST_BYTE;
      endcase
    end else begin
      rdata_q <= ust_pkg::RST_BYTE;
    end
  end

  assign o_rdata = rdata_q;
  assign o_ck = ck_q;
  assign o_ck_oe = active & clock_source_select_q;
  assign o_dt = dt_q;
  assign o_dt_oe = (mode_q == ust_pkg::UST_TX);
  assign o_irq = (rx_flag & irq_en_q[ust_pkg::IRQ_RX]) |
                 (tx_flag & irq_en_q[ust_pkg::IRQ_TX]);
endmodule

//--- hdl/ust_pkg.sv
// constants and types for the synchronous usart receive and transmit block
package ust_pkg;
  // register offsets
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h11;
  localparam logic [7:0] ADDR_RX_CS = 8'h13;
  localparam logic [7:0] ADDR_RX_BUF = 8'h14;
  localparam logic [7:0] ADDR_TX_CS = 8'h15;
  localparam logic [7:0] ADDR_TX_BUF = 8'h16;
  localparam logic [7:0] ADDR_BAUD = 8'h17;
  // rx_control_status fields
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_RX9 = 6;
  localparam int RX_SINGLE_WORD_RX_ENABLE = 5;
  localparam int RX_CONTINUOUS_RX_ENABLE = 4;
  localparam int RX_FRAMING_ERROR_FLAG = 2;
  localparam int RX_OVERRUN_ERROR_FLAG = 1;
  localparam int RX_R9D = 0;
  // tx_control_status fields
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_TX9 = 6;
  localparam int TX_TRANSMIT_ENABLE = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_TRMT = 1;
  localparam int TX_T9D = 0;
  // irq flag and enable fields
  localparam int IRQ_TX = 1;
  localparam int IRQ_RX = 0;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ_EN = 2'h0;
  localparam logic [7:0] RST_BAUD = 8'h00;
  // bit counts per word
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam int FIFO_DEPTH = 2;
  typedef struct packed {
    logic framing_error_flag;
    logic ninth;
    logic [7:0] data;
  } ust_rx_word_t;
  typedef enum logic [1:0] {
    UST_IDLE = 2'b00,
    UST_RX = 2'b01,
    UST_TX = 2'b10
  } ust_mode_t;
endpackage

//--- tb/ust_usart_sync_monitor.sv
// port assertions for the synchronous usart
`timescale 1ns/1ps
module ust_usart_sync_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pins and wake request
  input wire logic i_ck,
  input wire logic o_ck,
  input wire logic o_ck_oe,
  input wire logic i_dt,
  input wire logic o_dt,
  input wire logic o_dt_oe,
  input wire logic o_irq
);
  logic wrx, wtx, serial_port_enable_q, rxen_q, transmit_enable_q;
  logic [1:0] ie_q;
  logic [1:0] idle_q;
  assign wrx = i_wr && i_addr == ust_pkg::ADDR_RX_CS;
  assign wtx = i_wr && i_addr == ust_pkg::ADDR_TX_CS;
  // software view of the enables
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      serial_port_enable_q <= 1'h0;
      rxen_q <= 1'h0;
      transmit_enable_q <= 1'h0;
      ie_q <= 2'h0;
    end else begin
      if (wrx) serial_port_enable_q <= i_wdata[7];
      if (wrx) rxen_q <= i_wdata[5] | i_wdata[4];
      if (wtx) transmit_enable_q <= i_wdata[5];
      if (i_wr && i_addr == ust_pkg::ADDR_IRQ_EN) ie_q <= i_wdata[1:0];
    end
  end
  // cycles with receive and transmit enables clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || rxen_q || transmit_enable_q) idle_q <= 2'h0;
    else if (idle_q != 2'h3) idle_q <= idle_q + 2'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
  chk_unmapped_rd: assert property (
    i_rd && i_addr == 8'h12 |=> o_rdata == 8'h00) else $error("unmapped read");
  chk_slave_ck_in: assert property (
    wtx && !i_wdata[7] |=> !o_ck_oe) else $error("clock pin driven as slave");
  chk_master_ck_out: assert property (
    serial_port_enable_q && wtx && i_wdata[7] && i_wdata[4] |=> o_ck_oe)
    else $error("clock pin not driven as master");
  chk_rx_blocks_tx: assert property (
    wrx && i_wdata[7] && (i_wdata[5] || i_wdata[4]) |-> ##[1:4] !o_dt_oe)
    else $error("data pin driven while receiving");
  chk_tx_off: assert property (
    wtx && !i_wdata[5] |-> ##[1:4] !o_dt_oe) else $error("data pin kept");
  chk_gen_idle: assert property (
    idle_q == 2'h3 |-> !o_ck) else $error("shift clock runs while idle");
  chk_irq_masked: assert property (
    ie_q == 2'h0 |-> !o_irq) else $error("interrupt while masked");
endmodule
bind ust_usart_sync ust_usart_sync_monitor ust_usart_sync_monitor_inst (
  .i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_ck, .o_ck, .o_ck_oe, .i_dt, .o_dt, .o_dt_oe, .o_irq);

//--- tb/ust_peer_model.sv
// far-end synchronous serial peer
`timescale 1ns/1ps
module ust_peer_model (
  // clock
  input wire logic i_clk_sys,
  // resolved pin levels
  input wire logic i_ck_line,
  input wire logic i_dt_line,
  // peer drivers
  output logic o_ck,
  output logic o_dt
);
  logic busy, ck_d;
  logic [8:0] cap;
  initial begin
    o_ck = 1'h0;
    o_dt = 1'h0;
    busy = 1'h0;
    ck_d = 1'h0;
    cap = 9'h000;
  end
  // released data line changes every cycle; capture on falls
  always @(posedge i_clk_sys) begin
    ck_d <= i_ck_line;
    if (!busy) o_dt <= ~o_dt;
    if (ck_d && !i_ck_line) cap <= {i_dt_line, cap[8:1]};
  end
  // one word lsb first; slave=1 means the peer makes the clock
  task automatic put_word(input logic [8:0] w, input int n, input bit slave);
    int k;
    busy = 1'h1;
    for (int i = 0; i < n; i++) begin
      if (slave) begin
        @(posedge i_clk_sys);
        o_dt <= w[i];
        o_ck <= 1'h1;
        repeat (6) @(posedge i_clk_sys);
        o_ck <= 1'h0;
        repeat (6) @(posedge i_clk_sys);
      end else begin
        k = 0;
        do begin
          @(posedge i_clk_sys);
          k++;
        end while (!(i_ck_line && !ck_d) && k < 200);
        o_dt <= w[i];
      end
    end
    repeat (12) @(posedge i_clk_sys);
    busy = 1'h0;
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the synchronous usart
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys, i_rst_n, i_wr, i_rd, rd_d, o_ck, o_ck_oe, o_dt, o_dt_oe;
  logic o_irq, peer_ck, peer_dt, ck_line, dt_line;
  logic [7:0] i_addr, i_wdata, o_rdata, lfsr_q, w1;
  logic [8:0] wq [3];
  logic [15:0] exp_q [$];
  logic [15:0] e;
  int n_errors = 0;
  int num_checks = 0;
  assign ck_line = o_ck_oe ? o_ck : peer_ck;
  assign dt_line = o_dt_oe ? o_dt : peer_dt;
  ust_usart_sync ust_usart_sync_inst (.i_clk_sys, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ck(ck_line), .o_ck, .o_ck_oe,
    .i_dt(dt_line), .o_dt, .o_dt_oe, .o_irq);
  ust_peer_model ust_peer_model_inst (.i_clk_sys, .i_ck_line(ck_line),
    .i_dt_line(dt_line), .o_ck(peer_ck), .o_dt(peer_dt));
  function automatic logic [7:0] lfsr(input logic [7:0] q);
    return {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] x);
    num_checks++;
    if (seen !== x) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, x);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic [7:0] m = 8'hff);
    exp_q.push_back({m, x});
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (o_irq !== 1'h1 && k < 400) begin
      @(posedge i_clk_sys);
      k++;
    end
    check({8'h00, o_irq}, 9'h001);
    if (k >= 400) complete_run();
  endtask
  // read results checked in the slot after the strobe
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({1'h0, o_rdata & e[15:8]}, {1'h0, e[7:0]});
    end
  end
  initial begin
    i_clk_sys = 1'h0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    n_errors++;
    complete_run();
  end
  initial begin
    i_rst_n = 1'h0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'h0;
    i_rd = 1'h0;
    rd_d = 1'h0;
    lfsr_q = 8'h2d;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    rd(ust_pkg::ADDR_IRQ_FLAGS, 8'h02);
    rd(ust_pkg::ADDR_TX_CS, 8'h02);
    rd(ust_pkg::ADDR_IRQ_EN, 8'h00);
    rd(8'h12, 8'h00);
    lfsr_q = lfsr(lfsr_q);
    wr(ust_pkg::ADDR_BAUD, lfsr_q);
    rd(ust_pkg::ADDR_BAUD, lfsr_q);
    $display("test registers done");
    wr(ust_pkg::ADDR_BAUD, 8'h07);
    wr(ust_pkg::ADDR_RX_CS, 8'h80);
    wr(ust_pkg::ADDR_TX_CS, 8'h90);
    wr(ust_pkg::ADDR_IRQ_EN, 8'h01);
    lfsr_q = lfsr(lfsr_q);
    wr(ust_pkg::ADDR_RX_CS, 8'ha0);
    ust_peer_model_inst.put_word({1'h0, lfsr_q}, 8, 1'h0);
    wait_irq();
    rd(ust_pkg::ADDR_RX_CS, 8'h00, 8'h20);
    rd(ust_pkg::ADDR_RX_BUF, lfsr_q);
    rd(ust_pkg::ADDR_IRQ_FLAGS, 8'h00, 8'h01);
    $display("test single receive done");
    wr(ust_pkg::ADDR_RX_CS, 8'hf0);
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr(lfsr_q);
      wq[i] = {~i[0], lfsr_q};
      ust_peer_model_inst.put_word(wq[i], 9, 1'h0);
    end
    rd(ust_pkg::ADDR_RX_CS, 8'h12 | {7'h00, wq[0][8]}, 8'h13);
    rd(ust_pkg::ADDR_RX_BUF, wq[0][7:0]);
    rd(ust_pkg::ADDR_RX_CS, {7'h00, wq[1][8]}, 8'h01);
    rd(ust_pkg::ADDR_RX_BUF, wq[1][7:0]);
    repeat (300) @(posedge i_clk_sys);
    rd(ust_pkg::ADDR_IRQ_FLAGS, 8'h00, 8'h01);
    wr(ust_pkg::ADDR_RX_CS, 8'hc0);
    rd(ust_pkg::ADDR_RX_CS, 8'h00, 8'h02);
    $display("test overrun done");
    wr(ust_pkg::ADDR_RX_CS, 8'h80);
    wr(ust_pkg::ADDR_TX_CS, 8'h10);
    wr(ust_pkg::ADDR_IRQ_EN, 8'h02);
    w1 = lfsr(lfsr_q);
    wr(ust_pkg::ADDR_TX_BUF, w1);
    wr(ust_pkg::ADDR_TX_CS, 8'h30);
    wr(ust_pkg::ADDR_TX_BUF, lfsr(w1));
    rd(ust_pkg::ADDR_IRQ_FLAGS, 8'h00, 8'h02);
    ust_peer_model_inst.put_word(9'h000, 9, 1'h1);
    check({1'h0, ust_peer_model_inst.cap[7:0]}, {1'h0, w1});
    rd(ust_pkg::ADDR_IRQ_FLAGS, 8'h02, 8'h02);
    wait_irq();
    wr(ust_pkg::ADDR_TX_CS, 8'h10);
    rd(ust_pkg::ADDR_TX_CS, 8'h02, 8'h22);
    repeat (3) @(posedge i_clk_sys);
    $display("test slave transmit done");
    complete_run();
  end
endmodule
